//--- pkg/front_panel_defs.vh
// Constants shared by the front-panel control block and its testbench.
`ifndef FRONT_PANEL_DEFS_VH
`define FRONT_PANEL_DEFS_VH

// Register byte offsets on the APB bus.
`define OFS_CTRL 12'h000
`define OFS_FLAGS 12'h004
`define OFS_STATUS 12'h008
`define OFS_FUNC_CODE 12'h00c
`define OFS_SWITCHES 12'h010
`define OFS_ADDR_MASK 12'hffc

// Control register fields.
`define CTRL_RUN_SET 0
`define CTRL_SHIFT_EN 1
`define CTRL_SERIAL_IN 2
`define CTRL_READ_SWITCHES 3
`define CTRL_MEM_FUNC_MASK_LO 8
`define CTRL_MEM_FUNC_MASK_HI 15
`define CTRL_RESET_VAL 32'h0000_0000

// Flags register fields.
`define FLAG_ION 0
`define FLAG_FETCH 1
`define FLAG_DEFER 2
`define FLAG_EXECUTE 3
`define FLAG_CARRY 4

// Control discrete register stage positions.
`define STG_KEY 0
`define STG_RUN 1
`define STG_DCH 2
`define STG_KEYM 3

// Manual function code: low byte only, high byte ignored.
`define FUNC_CODE_HI 7
`define FUNC_CODE_RESET_VAL 8'h00

// Timing, in cycles of the 100 ns pclk.
`define CLK_PERIOD_NS 100
`define INIT_PULSE_NS 200
`define INIT_PULSE_CYCLES ((`INIT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_SWITCHES_INSTR_HOLD_NS 400
`define READ_SWITCHES_INSTR_HOLD_CYCLES ((`READ_SWITCHES_INSTR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COUNT_W 4

// Synchroniser reset: supplies low, bus and active-low switch pins at their idle high level.
`define PIN_SYNC_RESET 23'h1fffe7

`endif

//--- src/discrete_flag_reg.v
// Four-stage discrete flag register with master clear, load strobe and right shift.
module discrete_flag_reg
(
   input wire clk,
   input wire rst_n,
   input wire master_clear_input,
   input wire load_strobe,
   input wire shift_en,
   input wire serial_in_bit,
   input wire [3:0] d,
   output reg [3:0] q
);

   // Master clear beats both load and shift, so a clear pulse always wins.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= 4'h0;
      end
      else if (master_clear_input)
      begin
         q <= 4'h0;
      end
      else if (load_strobe)
      begin
         q <= d;
      end
      else if (shift_en)
      begin
         q <= {serial_in_bit, q[3:1]};
      end
   end

endmodule

//--- src/front_panel_control.v
// Front-panel control: initialising pulses, run gating, flags, lamps and panel requests.
//
// Function
// - Supply-good rise makes clear and load pulses
// - Panel clear release also makes both pulses
// - Any inhibit low zeroes run at phase five
// - Run sets only with inhibits high and set path
// - Clear pulse master-clears the flag register
// - Panel clear drops run before pulses
// - Flag stages load independently on load strobe
// - Shift mode moves right taking serial bit
// - Address lamps show shift register when stopped
// - Data lamps follow the memory bus
// - Carry, run, ion, state flags shown active low
// - Read switches drops data gate, disconnects memory
// - On request the switch gate line drops
// - Function codes active high, high byte ignored
// - State changes only on the clock edge
// - Request enters manual state, memory state if needed
`include "front_panel_defs.vh"

module front_panel_control
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire supply_good,
   input wire core_supply_good,
   input wire halt_n,
   input wire panel_clear_n,
   input wire panel_request_n,
   input wire timing_phase_five,
   input wire mem_clk_tick,
   input wire [15:0] membus_in,
   input wire [15:0] cpu_interface_shift_reg,
   output reg clear_pulse_n,
   output reg initial_load_pulse_n,
   output reg panel_data_gate_n,
   output reg memory_bus_disconnect,
   output reg panel_switch_gate_n,
   output reg [14:0] addr_lamps_n,
   output reg [15:0] data_lamps_n,
   output reg lamp_carry_n,
   output reg lamp_run_n,
   output reg lamp_ion_n,
   output reg lamp_fetch_n,
   output reg lamp_defer_n,
   output reg lamp_execute_n
);

   // Manual-function sequencer states, one-hot.
   localparam ST_IDLE = 3'b001;
   localparam ST_KEY = 3'b010;
   localparam ST_KEYM = 3'b100;

   // Two-stage synchronisers for every pin input. The switch pins and the bus reset to
   // their idle high level, so no false request or clear is seen as reset ends. The
   // supplies reset low, so a supply already good at release still gives one rise.
   reg [22:0] pin_meta_reg;
   reg [22:0] pin_sync_reg;
   wire supply_good_s;
   wire core_supply_good_s;
   wire halt_n_s;
   wire panel_clear_n_s;
   wire panel_request_n_s;
   wire phase_five_s;
   wire mem_tick_s;
   wire [15:0] membus_s;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_reg <= `PIN_SYNC_RESET;
         pin_sync_reg <= `PIN_SYNC_RESET;
      end
      else
      begin
         pin_meta_reg <= {core_supply_good, supply_good, membus_in, mem_clk_tick, timing_phase_five,
            panel_request_n, panel_clear_n, halt_n};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign supply_good_s = pin_sync_reg[21];
   assign core_supply_good_s = pin_sync_reg[22];
   assign halt_n_s = pin_sync_reg[0];
   assign panel_clear_n_s = pin_sync_reg[1];
   assign panel_request_n_s = pin_sync_reg[2];
   assign phase_five_s = pin_sync_reg[3];
   assign mem_tick_s = pin_sync_reg[4];
   assign membus_s = pin_sync_reg[20:5];

   // Initialising pulses: the clear switch is gated with supply good, and the rising
   // edge of the combined level starts a counted pulse. A capacitor cannot be trusted
   // in a synchronous design, so the width is a whole number of clocks instead.
   localparam [31:0] INIT_LOAD = `INIT_PULSE_CYCLES;
   localparam [31:0] READ_SWITCHES_INSTR_LOAD = `READ_SWITCHES_INSTR_HOLD_CYCLES;
   reg init_level_reg;
   reg [`COUNT_W-1:0] init_count_reg;
   wire init_level;
   wire init_rise;

   assign init_level = panel_clear_n_s & supply_good_s;
   assign init_rise = init_level & ~init_level_reg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         init_level_reg <= 1'b0;
         init_count_reg <= {`COUNT_W{1'b0}};
         clear_pulse_n <= 1'b1;
         initial_load_pulse_n <= 1'b1;
      end
      else
      begin
         init_level_reg <= init_level;
         if (init_rise)
         begin
            init_count_reg <= INIT_LOAD[`COUNT_W-1:0];
         end
         else if (init_count_reg != {`COUNT_W{1'b0}})
         begin
            init_count_reg <= init_count_reg - 1'b1;
         end
         clear_pulse_n <= ~(init_rise | (init_count_reg > 1));
         initial_load_pulse_n <= ~(init_rise | (init_count_reg > 1));
      end
   end

   wire master_clear_input;
   assign master_clear_input = ~clear_pulse_n;

   // Software registers.
   reg [31:0] ctrl_reg;
   reg [7:0] func_code_reg;
   reg [15:0] switches_reg;
   reg carry_reg;
   reg [2:0] state_reg;
   reg [`COUNT_W-1:0] read_switches_instr_count_reg;
   reg read_switches_instr_busy_reg;

   wire apb_done;
   wire apb_write;
   wire flags_write;
   wire read_switches_instr_start;
   assign apb_done = psel & penable & pready;
   assign apb_write = apb_done & pwrite;
   assign flags_write = apb_write & (paddr == `OFS_FLAGS);
   assign read_switches_instr_start = apb_write & (paddr == `OFS_CTRL) & pwdata[`CTRL_READ_SWITCHES];

   // Decodes whether an address is one of ours.
   function addr_mapped;
      input [11:0] a;
      begin
         addr_mapped = (a == `OFS_CTRL) | (a == `OFS_FLAGS) | (a == `OFS_STATUS) |
            (a == `OFS_FUNC_CODE) | (a == `OFS_SWITCHES);
      end
   endfunction

   // Control discrete register: key, run, dch and manual-memory stages.
   wire [3:0] ctrl_q;
   reg [3:0] ctrl_d;
   wire inhibit_ok;
   wire run_set_path;
   wire ctrl_load;

   assign inhibit_ok = panel_clear_n_s & supply_good_s & core_supply_good_s & halt_n_s;
   assign run_set_path = ctrl_reg[`CTRL_RUN_SET] | ctrl_q[`STG_RUN];
   assign ctrl_load = phase_five_s & mem_tick_s;

   // The manual stages follow the sequencer; run follows the inhibit gating.
   always @*
   begin
      ctrl_d = ctrl_q;
      ctrl_d[`STG_RUN] = inhibit_ok & run_set_path;
      ctrl_d[`STG_KEY] = (state_reg == ST_KEY);
      ctrl_d[`STG_KEYM] = (state_reg == ST_KEYM);
      ctrl_d[`STG_DCH] = 1'b0;
   end

   discrete_flag_reg ctrl_flags
   (
      .clk(pclk),
      .rst_n(presetn),
      .master_clear_input(master_clear_input),
      .load_strobe(ctrl_load),
      .shift_en(1'b0),
      .serial_in_bit(1'b0),
      .d(ctrl_d),
      .q(ctrl_q)
   );

   // Processor state flags, loaded by software or shifted when shift mode is on.
   wire [3:0] proc_q;
   wire proc_shift;
   assign proc_shift = ctrl_reg[`CTRL_SHIFT_EN] & ctrl_load;

   discrete_flag_reg proc_flags
   (
      .clk(pclk),
      .rst_n(presetn),
      .master_clear_input(master_clear_input),
      .load_strobe(flags_write),
      .shift_en(proc_shift),
      .serial_in_bit(ctrl_reg[`CTRL_SERIAL_IN]),
      .d(pwdata[3:0]),
      .q(proc_q)
   );

   // Manual-function sequencer. The panel already debounces its request, so a
   // synchronised low level is taken as one clean request.
   wire func_needs_mem;
   assign func_needs_mem = |(membus_s[7:0] & ctrl_reg[`CTRL_MEM_FUNC_MASK_HI:`CTRL_MEM_FUNC_MASK_LO]);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         func_code_reg <= `FUNC_CODE_RESET_VAL;
         panel_switch_gate_n <= 1'b1;
      end
      else if (master_clear_input)
      begin
         state_reg <= ST_IDLE;
         panel_switch_gate_n <= 1'b1;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (!panel_request_n_s)
               begin
                  state_reg <= ST_KEY;
                  panel_switch_gate_n <= 1'b0;
               end
            end
            ST_KEY:
            begin
               // Codes are active high; the upper byte is ignored.
               func_code_reg <= membus_s[`FUNC_CODE_HI:0];
               if (func_needs_mem)
               begin
                  state_reg <= ST_KEYM;
               end
               else if (panel_request_n_s)
               begin
                  state_reg <= ST_IDLE;
                  panel_switch_gate_n <= 1'b1;
               end
            end
            ST_KEYM:
            begin
               if (panel_request_n_s & mem_tick_s)
               begin
                  state_reg <= ST_IDLE;
                  panel_switch_gate_n <= 1'b1;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
               panel_switch_gate_n <= 1'b1;
            end
         endcase
      end
   end

   // Read-switches: the memories are cut off while the data gate is low, and the
   // switches are sampled at the end so the synchronised bus has settled.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         read_switches_instr_busy_reg <= 1'b0;
         read_switches_instr_count_reg <= {`COUNT_W{1'b0}};
         switches_reg <= 16'h0000;
         panel_data_gate_n <= 1'b1;
         memory_bus_disconnect <= 1'b0;
      end
      else if (read_switches_instr_start & ~read_switches_instr_busy_reg)
      begin
         read_switches_instr_busy_reg <= 1'b1;
         read_switches_instr_count_reg <= READ_SWITCHES_INSTR_LOAD[`COUNT_W-1:0];
         panel_data_gate_n <= 1'b0;
         memory_bus_disconnect <= 1'b1;
      end
      else if (read_switches_instr_busy_reg)
      begin
         if (read_switches_instr_count_reg == {`COUNT_W{1'b0}})
         begin
            switches_reg <= ~membus_s;
            read_switches_instr_busy_reg <= 1'b0;
            panel_data_gate_n <= 1'b1;
            memory_bus_disconnect <= 1'b0;
         end
         else
         begin
            read_switches_instr_count_reg <= read_switches_instr_count_reg - 1'b1;
         end
      end
   end

   // APB slave with one wait state, so prdata and pready both come from flops.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `CTRL_RESET_VAL;
         carry_reg <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready)
         begin
            pslverr <= ~addr_mapped(paddr);
            case (paddr)
               `OFS_CTRL: prdata <= ctrl_reg;
               `OFS_FLAGS: prdata <= {27'h0000000, carry_reg, proc_q};
               `OFS_STATUS: prdata <= {20'h00000, read_switches_instr_busy_reg, state_reg, ~init_level_reg,
                  inhibit_ok, ~clear_pulse_n, ~panel_switch_gate_n, ctrl_q};
               `OFS_FUNC_CODE: prdata <= {24'h000000, func_code_reg};
               `OFS_SWITCHES: prdata <= {16'h0000, switches_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
         else
         begin
            pslverr <= 1'b0;
         end
         if (master_clear_input)
         begin
            ctrl_reg[`CTRL_RUN_SET] <= 1'b0;
            carry_reg <= 1'b0;
         end
         else if (apb_write & (paddr == `OFS_CTRL))
         begin
            ctrl_reg <= {pwdata[31:4], 1'b0, pwdata[2:0]};
         end
         else if (flags_write)
         begin
            carry_reg <= pwdata[`FLAG_CARRY];
         end
         else if (ctrl_load & ctrl_q[`STG_RUN])
         begin
            // The continue request is used up once run has been taken.
            ctrl_reg[`CTRL_RUN_SET] <= 1'b0;
         end
      end
   end

   // Lamps, all active low. Address lamps read meaningless while running, so they are blanked.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_lamps_n <= 15'h7fff;
         data_lamps_n <= 16'hffff;
         lamp_carry_n <= 1'b1;
         lamp_run_n <= 1'b1;
         lamp_ion_n <= 1'b1;
         lamp_fetch_n <= 1'b1;
         lamp_defer_n <= 1'b1;
         lamp_execute_n <= 1'b1;
      end
      else
      begin
         addr_lamps_n <= ctrl_q[`STG_RUN] ? 15'h7fff : ~cpu_interface_shift_reg[14:0];
         data_lamps_n <= membus_s;
         lamp_carry_n <= ~carry_reg;
         lamp_run_n <= ~ctrl_q[`STG_RUN];
         lamp_ion_n <= ~proc_q[`FLAG_ION];
         lamp_fetch_n <= ~proc_q[`FLAG_FETCH];
         lamp_defer_n <= ~proc_q[`FLAG_DEFER];
         lamp_execute_n <= ~proc_q[`FLAG_EXECUTE];
      end
   end

endmodule

//--- testbench/front_panel_chk.sv
// Concurrent checks on the front-panel control block ports.
module front_panel_chk
(
   input wire pclk,
   input wire presetn,
   input wire supply_good,
   input wire panel_clear_n,
   input wire halt_n,
   input wire panel_request_n,
   input wire [15:0] membus_in,
   input wire clear_pulse_n,
   input wire initial_load_pulse_n,
   input wire panel_data_gate_n,
   input wire memory_bus_disconnect,
   input wire panel_switch_gate_n,
   input wire [15:0] data_lamps_n,
   input wire lamp_run_n,
   input wire lamp_ion_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // One clock domain, so the clock and the reset are given once here.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_pulse_pair: assert property (clear_pulse_n == initial_load_pulse_n)
      else $error("clear and load pulses differ");
   a_pulse_cause: assert property ($rose(supply_good && panel_clear_n) |-> ##[1:4] !clear_pulse_n)
      else $error("no init pulse after supply or clear release");
   a_pulse_width: assert property ($fell(clear_pulse_n) |=> !clear_pulse_n ##1 clear_pulse_n)
      else $error("init pulse not two cycles wide");
   a_clear_flags: assert property ($rose(clear_pulse_n) |-> lamp_run_n && lamp_ion_n)
      else $error("flags survive the clear pulse");
   a_run_inhibit: assert property (!halt_n [*8] |-> lamp_run_n)
      else $error("run kept while halted");
   a_read_switches_instr_pair: assert property (panel_data_gate_n == !memory_bus_disconnect)
      else $error("data gate and disconnect disagree");
   a_read_switches_instr_len: assert property ($fell(panel_data_gate_n) |-> !panel_data_gate_n [*5] ##1 panel_data_gate_n)
      else $error("read switches window has wrong length");
   a_gate_cause: assert property ($fell(panel_switch_gate_n) |-> !$past(panel_request_n, 3))
      else $error("switch gate fell without a request");
   // The lamp path resets its sync flops, so the first cycles after reset are skipped.
   a_data_lamps: assert property ($past(presetn, 3) |-> data_lamps_n == $past(membus_in, 3))
      else $error("data lamps do not follow the bus");
   c_pulse: cover property ($fell(clear_pulse_n));
   c_read_switches_instr: cover property ($fell(panel_data_gate_n));
   c_key: cover property ($fell(panel_switch_gate_n));
endmodule

//--- testbench/panel_model.sv
// Behavioural operator panel: switches, debounced request and bus drivers.
module panel_model
(
   input wire pclk,
   input wire panel_switch_gate_n,
   input wire memory_bus_disconnect,
   input wire panel_data_gate_n,
   output logic panel_request_n,
   output logic panel_clear_n,
   output logic [15:0] membus_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Stands in for the long debounce delay so that runs stay short.
   localparam int SETTLE = 4;
   logic [7:0] func_code = 8'h00;
   logic [15:0] data_sw = 16'h0000;
   logic [15:0] mem_word = 16'h0000;
   // Both switch lines start released.
   initial
   begin
      panel_request_n = 1'b1;
      panel_clear_n = 1'b1;
   end
   // Open-collector bus: gates can only pull bits low, so all drivers are ANDed.
   always_comb
   begin
      membus_in = (memory_bus_disconnect || !panel_switch_gate_n) ? 16'hffff : ~mem_word;
      if (!panel_data_gate_n)
         membus_in = membus_in & ~data_sw;
      if (!panel_switch_gate_n)
         membus_in = membus_in & {8'hff, func_code};
   end
   // Loads the data switches and the word held by the selected memory.
   task automatic set_words(input logic [15:0] sw, input logic [15:0] mem);
      @(posedge pclk);
      data_sw <= sw;
      mem_word <= mem;
   endtask
   // A control switch: the request falls once, cleanly, after the settle time.
   task automatic press(input logic [7:0] code);
      @(posedge pclk);
      func_code <= code;
      repeat (SETTLE) @(posedge pclk);
      panel_request_n <= 1'b0;
   endtask
   task automatic release_sw();
      @(posedge pclk);
      panel_request_n <= 1'b1;
   endtask
   // Reset has its own line and is never encoded on the bus.
   task automatic set_clear(input logic v);
      @(posedge pclk);
      panel_clear_n <= v;
   endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the front-panel control block.
`include "front_panel_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic supply_good, core_supply_good, halt_n, panel_clear_n, panel_request_n, mem_clk_tick;
   logic timing_phase_five = 1'b0;
   logic [15:0] membus_in, cpu_interface_shift_reg, data_lamps_n;
   logic [14:0] addr_lamps_n;
   logic clear_pulse_n, initial_load_pulse_n, panel_data_gate_n, memory_bus_disconnect, panel_switch_gate_n;
   logic lamp_carry_n, lamp_run_n, lamp_ion_n, lamp_fetch_n, lamp_defer_n, lamp_execute_n;
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;
   front_panel_control u_front_panel_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .supply_good, .core_supply_good, .halt_n, .panel_clear_n, .panel_request_n,
      .timing_phase_five, .mem_clk_tick, .membus_in, .cpu_interface_shift_reg, .clear_pulse_n,
      .initial_load_pulse_n, .panel_data_gate_n, .memory_bus_disconnect, .panel_switch_gate_n, .addr_lamps_n,
      .data_lamps_n, .lamp_carry_n, .lamp_run_n, .lamp_ion_n, .lamp_fetch_n, .lamp_defer_n, .lamp_execute_n);
   panel_model u_panel_model (.pclk, .panel_switch_gate_n, .memory_bus_disconnect, .panel_data_gate_n,
      .panel_request_n, .panel_clear_n, .membus_in);
   // Clock of 100 ns; phase five toggles so it meets the memory tick every other cycle.
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
      timing_phase_five <= ~timing_phase_five;
   // Cuts a hang short; the whole sequence needs far fewer cycles.
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One APB transfer: setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge pclk);
   endtask
   task automatic t_power();
      supply_good <= 1'b1;
      repeat (8) if (clear_pulse_n !== 1'b0) @(negedge pclk);
      chk(clear_pulse_n, 0);
      chk(initial_load_pulse_n, 0);
      settle(4);
      chk({lamp_run_n, lamp_ion_n, lamp_fetch_n, lamp_defer_n, lamp_execute_n}, 32'h1f);
      $display("test power_up done");
   endtask
   task automatic t_regs();
      apb(1'b0, `OFS_CTRL, 0);
      chk(rdat, `CTRL_RESET_VAL);
      apb(1'b1, `OFS_FLAGS, 32'h15);
      apb(1'b0, `OFS_FLAGS, 0);
      chk(rdat, 32'h15);
      settle(3);
      chk({lamp_carry_n, lamp_ion_n, lamp_fetch_n, lamp_defer_n, lamp_execute_n}, 32'h05);
      apb(1'b1, `OFS_FLAGS, 32'h0a);
      settle(3);
      chk({lamp_carry_n, lamp_ion_n, lamp_fetch_n, lamp_defer_n, lamp_execute_n}, 32'h1a);
      apb(1'b0, 12'h014, 0);
      chk(rerr, 1);
      chk(rdat, 0);
      $display("test registers done");
   endtask
   task automatic t_shift();
      apb(1'b1, `OFS_FLAGS, 0);
      apb(1'b1, `OFS_CTRL, 32'h6);
      settle(20);
      apb(1'b0, `OFS_FLAGS, 0);
      chk(rdat & 32'hf, 32'hf);
      apb(1'b1, `OFS_CTRL, 32'h2);
      settle(20);
      apb(1'b0, `OFS_FLAGS, 0);
      chk(rdat & 32'hf, 32'h0);
      apb(1'b1, `OFS_CTRL, 0);
      $display("test shift done");
   endtask
   task automatic t_run();
      apb(1'b1, `OFS_CTRL, 32'h1);
      settle(10);
      chk(lamp_run_n, 0);
      chk(addr_lamps_n, 15'h7fff);
      @(posedge pclk);
      halt_n <= 1'b0;
      settle(10);
      chk(lamp_run_n, 1);
      chk(addr_lamps_n, 15'(~cpu_interface_shift_reg[14:0]));
      @(posedge pclk);
      halt_n <= 1'b1;
      settle(10);
      chk(lamp_run_n, 1);
      $display("test run done");
   endtask
   task automatic t_clear();
      apb(1'b1, `OFS_CTRL, 32'h1);
      settle(10);
      u_panel_model.set_clear(1'b0);
      settle(10);
      chk({lamp_run_n, clear_pulse_n}, 32'h3);
      u_panel_model.set_clear(1'b1);
      repeat (8) if (clear_pulse_n !== 1'b0) @(negedge pclk);
      chk(clear_pulse_n, 0);
      $display("test panel_clear done");
   endtask
   task automatic t_read_switches_instr();
      u_panel_model.set_words(16'h1234, 16'h0f0f);
      apb(1'b1, `OFS_CTRL, 32'h8);
      repeat (8) if (panel_data_gate_n !== 1'b0) @(negedge pclk);
      chk({panel_data_gate_n, memory_bus_disconnect}, 32'h1);
      settle(10);
      apb(1'b0, `OFS_SWITCHES, 0);
      chk(rdat, 32'h1234);
      chk(data_lamps_n, 16'hf0f0);
      $display("test read_switches done");
   endtask
   task automatic t_request();
      u_panel_model.press(8'h33);
      repeat (12) if (panel_switch_gate_n !== 1'b0) @(negedge pclk);
      chk(panel_switch_gate_n, 0);
      settle(4);
      apb(1'b0, `OFS_FUNC_CODE, 0);
      chk(rdat, 32'h33);
      u_panel_model.release_sw();
      settle(8);
      chk(panel_switch_gate_n, 1);
      apb(1'b1, `OFS_CTRL, 32'h100);
      u_panel_model.press(8'h33);
      settle(12);
      apb(1'b0, `OFS_STATUS, 0);
      chk(rdat & 32'h8, 32'h8);
      u_panel_model.release_sw();
      settle(8);
      chk(panel_switch_gate_n, 1);
      $display("test request done");
   endtask
   // Main sequence: quiet inputs, ten cycles of reset, then the scenarios.
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      supply_good = 1'b0;
      core_supply_good = 1'b1;
      halt_n = 1'b1;
      mem_clk_tick = 1'b1;
      cpu_interface_shift_reg = 16'h2a5c;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_power();
      t_regs();
      t_shift();
      t_run();
      t_clear();
      t_read_switches_instr();
      t_request();
      report_and_stop();
   end
endmodule
bind front_panel_control front_panel_chk u_front_panel_chk (.pclk, .presetn, .supply_good, .panel_clear_n,
   .halt_n, .panel_request_n, .membus_in, .clear_pulse_n, .initial_load_pulse_n, .panel_data_gate_n,
   .memory_bus_disconnect, .panel_switch_gate_n, .data_lamps_n, .lamp_run_n, .lamp_ion_n);
